// file: rtc_mode_and_event_status.sv
// mode control, time keeping and event status of the real-time clock
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_mode_and_event_status #(
    // cycles per second update, shorten for simulation
    parameter int unsigned SEC_CYCLES =
        `RTC_CLK_HZ / `RTC_MS_PER_S * `RTC_UPDATE_PERIOD_MS
) (
    input wire logic i_clk,              // 125 MHz clock
    input wire logic i_rst_n,            // synchronous reset, low
    // axi4-lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic [2:0] i_awprot,
    // axi4-lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // axi4-lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // axi4-lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    input wire logic [2:0] i_arprot,
    // axi4-lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // event sources from the rate and alarm logic
    input wire logic i_periodic_evt,     // one-cycle pulse
    input wire logic i_alarm_evt,        // one-cycle pulse
    // level interrupt
    output logic o_irq
);
    import rtc_pkg::*;

    // ------------------------------------------------------------
    // state and wires
    // ------------------------------------------------------------
    rtc_state_t st_r;                 // registered state
    rtc_state_t st_nxt;               // next state
    rtc_state_t st_rst;               // reset image
    logic [7:0] rd_raw;               // internal value at read index
    logic rd_is_hour;                 // read targets the hours
    logic [7:0] rd_host;              // value as host sees it
    logic [7:0] wr_int;               // written value, internal form
    logic [5:0] rd_idx;               // read index

    assign rd_idx = i_araddr[7:2];
    assign rd_is_hour = (rd_idx == `RTC_IDX_HOURS);

    // ------------------------------------------------------------
    // read presentation
    // ------------------------------------------------------------
    // raw internal value picked for conversion
    always_comb begin
        unique case (rd_idx)
            `RTC_IDX_SECONDS: rd_raw = {2'b00, st_r.sec};
            `RTC_IDX_MINUTES: rd_raw = {2'b00, st_r.min};
            `RTC_IDX_HOURS: rd_raw = {3'b000, st_r.hour};
            `RTC_IDX_DST_FWD_HOUR: rd_raw = {3'b000, st_r.dst_fwd};
            `RTC_IDX_DST_BWD_HOUR: rd_raw = {3'b000, st_r.dst_bwd};
            default: rd_raw = 8'h00;
        endcase
    end

    // current mode bits used at the moment of access
    rtc_present_conv #(.TO_HOST(1'b1)) u_rd_conv (
        .i_val(rd_raw),
        .i_binary(st_r.mode[`RTC_B_DM]),
        .i_hr24(st_r.mode[`RTC_B_HR24]),
        .i_is_hour(rd_is_hour || rd_idx == `RTC_IDX_DST_FWD_HOUR
            || rd_idx == `RTC_IDX_DST_BWD_HOUR),
        .o_val(rd_host)
    );

    // ------------------------------------------------------------
    // write interpretation
    // ------------------------------------------------------------
    // written time values are decoded once into binary storage
    rtc_present_conv #(.TO_HOST(1'b0)) u_wr_conv (
        .i_val(st_r.wdata),
        .i_binary(st_r.mode[`RTC_B_DM]),
        .i_hr24(st_r.mode[`RTC_B_HR24]),
        .i_is_hour(st_r.aw_idx == `RTC_IDX_HOURS
            || st_r.aw_idx == `RTC_IDX_DST_FWD_HOUR
            || st_r.aw_idx == `RTC_IDX_DST_BWD_HOUR),
        .o_val(wr_int)
    );

    // ------------------------------------------------------------
    // reset image
    // ------------------------------------------------------------
    // every field at its quiet value, ready raised for the bus
    always_comb begin
        st_rst = '0;
        st_rst.awready = 1'b1;
        st_rst.wready = 1'b1;
        st_rst.arready = 1'b1;
        st_rst.mode = `RTC_MODE_RESET;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic tick;            // one-second boundary
        logic do_write;        // both write halves present
        logic rd_take;         // read address taken now
        logic rd_stat;         // the event status is being read
        logic wr_stat_clr;     // write-one clear of event flags
        logic [2:0] ev;        // events this cycle
        logic [2:0] enabled;   // flags passing their enables
        logic [7:0] stat_byte; // event status as read
        tick = 1'b0;
        do_write = 1'b0;
        rd_take = 1'b0;
        rd_stat = 1'b0;
        wr_stat_clr = 1'b0;
        ev = 3'b000;
        enabled = 3'b000;
        stat_byte = 8'h00;
        st_nxt = st_r;

        // self-reset pulse: restore all but the request, which drops
        if (st_r.soft_rst) begin
            st_nxt = st_rst;
        end else begin
            // --- write channel capture, either order ---
            if (i_awvalid && st_r.awready) begin
                st_nxt.aw_held = 1'b1;
                st_nxt.aw_idx = i_awaddr[7:2];
                st_nxt.awready = 1'b0;
            end
            if (i_wvalid && st_r.wready) begin
                st_nxt.w_held = 1'b1;
                st_nxt.wdata = i_wdata[7:0];
                st_nxt.wstrb0 = i_wstrb[0];
                st_nxt.wready = 1'b0;
            end
            do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;

            // --- one-second prescaler ---
            if (st_r.presc == 27'(SEC_CYCLES - 1)) begin
                st_nxt.presc = '0;
                tick = 1'b1;
            end else begin
                st_nxt.presc = st_r.presc + 27'd1;
            end

            // --- time advance, suppressed while held ---
            if (tick && !st_r.mode[`RTC_B_HOLD]) begin
                ev[0] = 1'b1;
                if (st_r.sec >= `RTC_SEC_MAX) begin
                    st_nxt.sec = '0;
                    if (st_r.min >= `RTC_MIN_MAX) begin
                        st_nxt.min = '0;
                        if (st_r.hour >= `RTC_HOUR_MAX) begin
                            st_nxt.hour = '0;
                            st_nxt.dst_bwd_done = 1'b0;
                        end else begin
                            st_nxt.hour = st_r.hour + 5'd1;
                        end
                        // daylight step on the hour boundary
                        if (st_r.mode[`RTC_B_DSE]) begin
                            if (st_nxt.hour == st_r.dst_fwd) begin
                                st_nxt.hour =
                                    (st_nxt.hour >= `RTC_HOUR_MAX)
                                    ? 5'd0 : st_nxt.hour + 5'd1;
                            end else if (st_nxt.hour == st_r.dst_bwd
                                && !st_r.dst_bwd_done) begin
                                // step back once, hour repeats
                                st_nxt.hour = (st_nxt.hour == 5'd0)
                                    ? `RTC_HOUR_MAX : st_nxt.hour - 5'd1;
                                st_nxt.dst_bwd_done = 1'b1;
                            end
                        end
                    end else begin
                        st_nxt.min = st_r.min + 6'd1;
                    end
                end else begin
                    st_nxt.sec = st_r.sec + 6'd1;
                end
            end
            // next change is a full second away, so values stay stable

            // --- register write, after the time advance ---
            if (do_write) begin
                st_nxt.bvalid = 1'b1;
                st_nxt.bresp = `RTC_RESP_OKAY;
                if (st_r.wstrb0) begin
                    unique case (st_r.aw_idx)
                        `RTC_IDX_SECONDS: st_nxt.sec = wr_int[5:0];
                        `RTC_IDX_MINUTES: st_nxt.min = wr_int[5:0];
                        `RTC_IDX_HOURS: st_nxt.hour = wr_int[4:0];
                        `RTC_IDX_MODE_CTRL: begin
                            // reserved bit stays zero
                            st_nxt.mode = st_r.wdata
                                & `RTC_MODE_WMASK;
                        end
                        `RTC_IDX_EVENT_STAT: begin
                            wr_stat_clr = 1'b1;
                        end
                        `RTC_IDX_DST_FWD_HOUR: begin
                            st_nxt.dst_fwd = wr_int[4:0];
                        end
                        `RTC_IDX_DST_BWD_HOUR: begin
                            st_nxt.dst_bwd = wr_int[4:0];
                        end
                        `RTC_IDX_BLOCK_CTRL: begin
                            st_nxt.soft_rst =
                                st_r.wdata[`RTC_BC_SOFT_RST];
                        end
                        default: st_nxt.bresp = `RTC_RESP_SLVERR;
                    endcase
                end else if (!(st_r.aw_idx == `RTC_IDX_SECONDS
                    || st_r.aw_idx == `RTC_IDX_MINUTES
                    || st_r.aw_idx == `RTC_IDX_HOURS
                    || st_r.aw_idx == `RTC_IDX_MODE_CTRL
                    || st_r.aw_idx == `RTC_IDX_EVENT_STAT
                    || st_r.aw_idx == `RTC_IDX_DST_FWD_HOUR
                    || st_r.aw_idx == `RTC_IDX_DST_BWD_HOUR
                    || st_r.aw_idx == `RTC_IDX_BLOCK_CTRL)) begin
                    // unmapped index answers an error
                    st_nxt.bresp = `RTC_RESP_SLVERR;
                end
            end

            // --- write response retire ---
            if (st_r.bvalid && i_bready) begin
                st_nxt.bvalid = 1'b0;
                st_nxt.aw_held = 1'b0;
                st_nxt.w_held = 1'b0;
                st_nxt.awready = 1'b1;
                st_nxt.wready = 1'b1;
            end

            // --- read channel ---
            rd_take = i_arvalid && st_r.arready;
            enabled = st_r.flags
                & st_r.mode[`RTC_EN_HI:`RTC_EN_LO];
            stat_byte[`RTC_C_IRQF] = |enabled;
            stat_byte[`RTC_C_FLAGS_HI:`RTC_C_FLAGS_LO] = st_r.flags;
            if (rd_take) begin
                st_nxt.arready = 1'b0;
                st_nxt.rvalid = 1'b1;
                st_nxt.rresp = `RTC_RESP_OKAY;
                unique case (rd_idx)
                    `RTC_IDX_SECONDS,
                    `RTC_IDX_MINUTES,
                    `RTC_IDX_HOURS,
                    `RTC_IDX_DST_FWD_HOUR,
                    `RTC_IDX_DST_BWD_HOUR: begin
                        st_nxt.rdata = rd_host;
                    end
                    `RTC_IDX_MODE_CTRL: st_nxt.rdata = st_r.mode;
                    `RTC_IDX_EVENT_STAT: begin
                        st_nxt.rdata = stat_byte;
                        rd_stat = 1'b1;
                    end
                    `RTC_IDX_BLOCK_CTRL: begin
                        st_nxt.rdata = {7'h00, st_r.soft_rst};
                    end
                    default: begin
                        st_nxt.rdata = 8'h00;
                        st_nxt.rresp = `RTC_RESP_SLVERR;
                    end
                endcase
            end
            if (st_r.rvalid && i_rready) begin
                st_nxt.rvalid = 1'b0;
                st_nxt.arready = 1'b1;
            end

            // --- event flags: clear by read or write-one, set wins ---
            ev[2] = i_periodic_evt;
            ev[1] = i_alarm_evt;
            if (rd_stat) begin
                st_nxt.flags = 3'b000;
            end
            if (wr_stat_clr) begin
                st_nxt.flags = st_nxt.flags & ~st_r.wdata[6:4];
            end
            st_nxt.flags = st_nxt.flags | ev;

            // --- interrupt level from enabled flags ---
            st_nxt.irq = |(st_nxt.flags
                & st_nxt.mode[`RTC_EN_HI:`RTC_EN_LO]);
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r <= st_rst;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from flip-flops
    // ------------------------------------------------------------
    assign o_awready = st_r.awready;
    assign o_wready = st_r.wready;
    assign o_bvalid = st_r.bvalid;
    assign o_bresp = st_r.bresp;
    assign o_arready = st_r.arready;
    assign o_rvalid = st_r.rvalid;
    assign o_rdata = {24'h00_0000, st_r.rdata};
    assign o_rresp = st_r.rresp;
    assign o_irq = st_r.irq;

endmodule : rtc_mode_and_event_status

// file: rtc_mode_and_event_status_checker.sv
// port assertions for the clock mode and event status block
`timescale 1ns/1ps
module rtc_mode_and_event_status_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic o_bvalid,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [7:0] i_araddr,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic i_periodic_evt,
    input wire logic i_alarm_evt,
    input wire logic o_irq
);
    // ------------------------------------------------------------
    // shadow of the three interrupt enables
    // ------------------------------------------------------------
    logic [2:0] en_r; // periodic, alarm, update enables
    logic wr_mode; // mode word taken this cycle
    assign wr_mode = i_awvalid && o_awready && i_wvalid && o_wready
        && i_awaddr == 8'h2c && i_wstrb[0];
    // track enables as written
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            en_r <= 3'h0;
        end else if (wr_mode) begin
            en_r <= i_wdata[6:4];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_take;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_wr_answer;
        !o_awready ##1 o_bvalid;
    endsequence
    a_write_answer: assert property (s_wr_take |=> s_wr_answer)
        else $error("write answer late");
    a_read_answer: assert property (i_arvalid && o_arready |=>
        o_rvalid && !o_arready) else $error("read answer late");
    a_rdata_hold: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read data not held");
    a_rdata_upper: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_read: assert property (i_arvalid && o_arready &&
        i_araddr == 8'hfc |=> o_rresp == 2'b10 && o_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_reset_image: assert property ($rose(i_rst_n) |-> o_awready &&
        o_wready && o_arready && !o_bvalid && !o_rvalid && !o_irq)
        else $error("bad state after reset");
    a_periodic_irq: assert property (
        i_periodic_evt && en_r[2] |=> o_irq) else $error("periodic irq");
    a_alarm_irq: assert property (
        i_alarm_evt && en_r[1] |=> o_irq) else $error("alarm irq");
endmodule : rtc_mode_and_event_status_checker

bind rtc_mode_and_event_status rtc_mode_and_event_status_checker
    checker_inst (.i_clk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr,
    .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_arvalid,
    .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
    .i_periodic_evt, .i_alarm_evt, .o_irq);

// file: rtc_mode_and_event_status_tb.sv
// self-checking bench for the clock mode and event status block
`timescale 1ns/1ps
module rtc_mode_and_event_status_tb;
    logic i_clk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0;
    logic i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic i_periodic_evt = 0, i_alarm_evt = 0;
    logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
    logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'h0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic [1:0] o_bresp, o_rresp, rs;
    logic [31:0] o_rdata, rv, s1;
    int bad_count = 0, total_checks = 0;
    rtc_mode_and_event_status #(.SEC_CYCLES(20))
        rtc_mode_and_event_status_inst (.i_clk, .i_rst_n, .i_awvalid,
        .o_awready, .i_awaddr, .i_awprot, .i_wvalid, .o_wready, .i_wdata,
        .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
        .i_araddr, .i_arprot, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
        .i_periodic_evt, .i_alarm_evt, .o_irq);
    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    // write one byte, bready held up so a self-reset answer is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ha, hw, hb;
        bit done;
        done = 0;
        @(posedge i_clk);
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_awaddr <= a;
        i_wdata <= {24'h0, d};
        i_wstrb <= 4'h1;
        i_bready <= 1'b1;
        while (!done) begin
            @(negedge i_clk);
            ha = i_awvalid && o_awready;
            hw = i_wvalid && o_wready;
            hb = o_bvalid && i_bready;
            if (hb) rs = o_bresp;
            @(posedge i_clk);
            if (ha) i_awvalid <= 1'b0;
            if (hw) i_wvalid <= 1'b0;
            if (hb) begin
                i_bready <= 1'b0;
                done = 1;
            end
        end
    endtask : wr
    // read one word, rready raised only once data shows (a stall)
    task automatic rd(input logic [7:0] a);
        logic ha, hv, hr;
        bit done;
        done = 0;
        @(posedge i_clk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        while (!done) begin
            @(negedge i_clk);
            ha = i_arvalid && o_arready;
            hv = o_rvalid;
            hr = o_rvalid && i_rready;
            if (hr) rv = o_rdata;
            if (hr) rs = o_rresp;
            @(posedge i_clk);
            if (ha) i_arvalid <= 1'b0;
            if (hv && !hr) i_rready <= 1'b1;
            if (hr) begin
                i_rready <= 1'b0;
                done = 1;
            end
        end
    endtask : rd
    // one-cycle event pulse, then settle to the falling edge
    task automatic pulse(input bit alarm);
        @(posedge i_clk);
        if (alarm) i_alarm_evt <= 1'b1;
        else i_periodic_evt <= 1'b1;
        @(posedge i_clk);
        i_alarm_evt <= 1'b0;
        i_periodic_evt <= 1'b0;
        @(negedge i_clk);
    endtask : pulse
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_map;
        rd(8'h2c);
        chk(rv, 32'h0);
        repeat (25) @(negedge i_clk);
        rd(8'h30);
        chk(rv, 32'h10);
        chk(o_irq, 1'b0);
        rd(8'hfc);
        chk(rs, 2'b10);
        wr(8'hfc, 8'h00);
        chk(rs, 2'b10);
        wr(8'h2c, 8'hff);
        chk(rs, 2'b00);
        rd(8'h2c);
        chk(rv, 32'hf7);
    endtask : t_reset_and_map
    task automatic t_format;
        wr(8'h2c, 8'h86);
        wr(8'h00, 8'h25);
        wr(8'h10, 8'h0d);
        wr(8'h2c, 8'h80);
        rd(8'h00);
        chk(rv, 32'h37);
        rd(8'h10);
        chk(rv, 32'h81);
        wr(8'h2c, 8'h82);
        rd(8'h10);
        chk(rv, 32'h13);
    endtask : t_format
    task automatic t_update;
        rd(8'h30);
        wr(8'h2c, 8'h10);
        for (int n = 0; n < 60 && !o_irq; n++) @(negedge i_clk);
        chk(o_irq, 1'b1);
        rd(8'h30);
        chk(rv, 32'h90);
        wr(8'h2c, 8'h80);
        rd(8'h00);
        s1 = rv;
        chk(s1, 32'h38);
        repeat (60) @(negedge i_clk);
        rd(8'h00);
        chk(rv, s1);
        wr(8'h80, 8'h05);
        wr(8'h10, 8'h04);
        wr(8'h08, 8'h59);
        wr(8'h00, 8'h59);
        wr(8'h2c, 8'h03);
        repeat (25) @(negedge i_clk);
        rd(8'h10);
        chk(rv, 32'h06);
    endtask : t_update
    task automatic t_events;
        wr(8'h2c, 8'ha0);
        rd(8'h30);
        pulse(1'b0);
        chk(o_irq, 1'b0);
        pulse(1'b1);
        chk(o_irq, 1'b1);
        rd(8'h30);
        chk(rv, 32'he0);
        @(negedge i_clk);
        chk(o_irq, 1'b0);
        rd(8'h30);
        chk(rv, 32'h0);
        wr(8'h2c, 8'hc0);
        pulse(1'b0);
        chk(o_irq, 1'b1);
    endtask : t_events
    task automatic t_self_reset;
        wr(8'h88, 8'h01);
        rd(8'h2c);
        chk(rv, 32'h0);
        rd(8'h88);
        chk(rv, 32'h0);
        chk(o_irq, 1'b0);
    endtask : t_self_reset
    task automatic wrap_up;
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_reset_and_map();
        t_format();
        t_update();
        t_events();
        t_self_reset();
        wrap_up();
    end
endmodule : rtc_mode_and_event_status_tb

// file: rtc_params.svh
// constants of the real-time clock mode and event status block
// Functional notes
// - advance time once per second while not held
// - hold bit stops updates, clearing resumes them
// - periodic enable gates periodic events onto interrupt
// - alarm enable gates alarm events onto interrupt
// - update enable gates update-ended events onto interrupt
// - format bit: one binary, zero bcd
// - daylight enable adjusts hour at programmed hours
// - formats convert only at access, storage unchanged
// - format changes apply at next access
// - request bit is any enabled flag set
// - status read clears request and all flags
// - periodic flag sticky regardless of its enable
// - alarm flag sticky regardless of its enable
// - update flag sticky regardless of its enable
// - time stable over 999 ms after update
// - self-reset clears all but itself, self-clears
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define RTC_IDX_SECONDS 6'h00
`define RTC_IDX_MINUTES 6'h02
`define RTC_IDX_HOURS 6'h04
`define RTC_IDX_MODE_CTRL 6'h0b
`define RTC_IDX_EVENT_STAT 6'h0c
`define RTC_IDX_DST_FWD_HOUR 6'h20
`define RTC_IDX_DST_BWD_HOUR 6'h21
`define RTC_IDX_BLOCK_CTRL 6'h22

// ------------------------------------------------------------
// mode control fields
// ------------------------------------------------------------
`define RTC_B_HOLD 7
`define RTC_B_PIE 6
`define RTC_B_AIE 5
`define RTC_B_UIE 4
`define RTC_B_DM 2
`define RTC_B_HR24 1
`define RTC_B_DSE 0
`define RTC_MODE_WMASK 8'hf7
`define RTC_MODE_RESET 8'h00

// ------------------------------------------------------------
// event status fields
// ------------------------------------------------------------
`define RTC_C_IRQF 7
`define RTC_C_FLAGS_HI 6
`define RTC_C_FLAGS_LO 4
`define RTC_EN_HI 6
`define RTC_EN_LO 4

// ------------------------------------------------------------
// block control, time limits, bus answers
// ------------------------------------------------------------
`define RTC_BC_SOFT_RST 0
`define RTC_SEC_MAX 6'd59
`define RTC_MIN_MAX 6'd59
`define RTC_HOUR_MAX 5'd23
`define RTC_HOUR_NOON 5'd12
`define RTC_HOUR_PM_BIT 7
`define RTC_RESP_OKAY 2'b00
`define RTC_RESP_SLVERR 2'b10
`define RTC_CLK_HZ 125000000
`define RTC_UPDATE_PERIOD_MS 1000
`define RTC_MS_PER_S 1000

`endif

// file: rtc_pkg.sv
// types of the real-time clock mode and event status block
package rtc_pkg;

    // ------------------------------------------------------------
    // whole state of the top module
    // ------------------------------------------------------------
    typedef struct packed {
        logic awready;       // write address ready
        logic wready;        // write data ready
        logic aw_held;       // write address captured
        logic w_held;        // write data captured
        logic [5:0] aw_idx;  // captured write index
        logic [7:0] wdata;   // captured write byte
        logic wstrb0;        // captured low lane strobe
        logic bvalid;        // write response valid
        logic [1:0] bresp;   // write response code
        logic arready;       // read address ready
        logic rvalid;        // read data valid
        logic [7:0] rdata;   // read data byte
        logic [1:0] rresp;   // read response code
        logic [7:0] mode;    // clock mode control
        logic [2:0] flags;   // periodic, alarm, update flags
        logic irq;           // interrupt output
        logic [26:0] presc;  // one-second prescaler
        logic [5:0] sec;     // seconds, binary
        logic [5:0] min;     // minutes, binary
        logic [4:0] hour;    // hours 0..23, binary
        logic [4:0] dst_fwd; // forward hour
        logic [4:0] dst_bwd; // backward hour
        logic dst_bwd_done;  // backward step taken today
        logic soft_rst;      // self-reset request
    } rtc_state_t;

endpackage : rtc_pkg

// file: rtc_present_conv.sv
// converts a time value between internal binary and host presentation
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_present_conv #(
    parameter bit TO_HOST = 1'b1 // one: internal to host, zero: reverse
) (
    input wire logic [7:0] i_val,   // value to convert
    input wire logic i_binary,      // one binary, zero bcd
    input wire logic i_hr24,        // one 24-hour, zero 12-hour
    input wire logic i_is_hour,     // value is an hour
    output logic [7:0] o_val        // converted value
);

    // ------------------------------------------------------------
    // conversion
    // ------------------------------------------------------------
    // one pass of combinational logic, no storage touched
    always_comb begin
        logic [7:0] num;
        logic [7:0] dec;
        logic pm;
        num = 8'h00;
        dec = 8'h00;
        pm = 1'b0;
        if (TO_HOST) begin
            num = i_val;
            // 12-hour: 0 shows as 12, afternoon flagged
            if (i_is_hour && !i_hr24) begin
                pm = (i_val >= 8'(`RTC_HOUR_NOON));
                if (pm) begin
                    num = i_val - 8'(`RTC_HOUR_NOON);
                end
                if (num == 8'h00) begin
                    num = 8'(`RTC_HOUR_NOON);
                end
            end
            // bcd digits when not binary
            dec = i_binary ? num : {4'(num / 8'd10), 4'(num % 8'd10)};
            o_val = dec | {pm, 7'h00};
        end else begin
            // strip the afternoon flag only for a 12-hour hour
            pm = i_is_hour && !i_hr24 && i_val[`RTC_HOUR_PM_BIT];
            dec = pm ? {1'b0, i_val[6:0]} : i_val;
            num = i_binary ? dec : 8'(dec[7:4] * 8'd10 + {4'h0, dec[3:0]});
            if (i_is_hour && !i_hr24) begin
                if (num == 8'(`RTC_HOUR_NOON)) begin
                    num = 8'h00;
                end
                num = pm ? num + 8'(`RTC_HOUR_NOON) : num;
            end
            o_val = num;
        end
    end

endmodule : rtc_present_conv
